/* bench/heth_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Host processor on the register port: one request held across its taking edge
module heth_host_model (
  // Clock
  input  wire logic        i_clock,
  // Register port towards the device
  output logic             o_cs,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [7:0]  o_addr,
  output logic      [1:0]  o_be,
  output logic      [15:0] o_wdata,
  // Read answer
  input  wire logic [15:0] i_rdata
);
  // Idle bus at time zero
  initial begin
    o_cs = 1'b0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_be = 2'b00;
    o_wdata = 16'h0000;
  end

  // One write; released address and data lines show the inverse so stale data never looks valid
  task automatic wr16(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge i_clock);
    o_cs <= 1'b1;
    o_wr <= 1'b1;
    o_addr <= a;
    o_be <= b;
    o_wdata <= d;
    @(posedge i_clock);
    o_cs <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_be <= 2'b00;
    o_wdata <= ~d;
  endtask

  // One read; the answer is taken once the taking edge has landed
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clock);
    o_cs <= 1'b1;
    o_rd <= 1'b1;
    o_addr <= a;
    o_be <= 2'b11;
    @(posedge i_clock);
    o_cs <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    // Registered answer has stood a whole cycle by the next edge
    @(posedge i_clock);
    d = i_rdata;
  endtask

  // Threshold set-up; a zero frame count is never left armed
  task automatic set_rx_thr(input logic [7:0] bt, input logic [7:0] ft, input logic f_en);
    wr16(8'h9c, 2'b11, {bt, (f_en && ft == 8'h00) ? 8'h01 : ft});
  endtask

  // Next transmit request, a count of double words
  task automatic req_space(input logic [15:0] dw);
    wr16(8'h9e, 2'b11, dw);
  endtask
endmodule
`default_nettype wire

/* bench/heth_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Self-checking bench for the status, threshold and hash registers
module heth_regs_bench;
  import heth_pkg::*;
  logic i_clock = 1'b0, i_rst_n = 1'b0, cs, wr, rd, pm_wr = 1'b0, b_en = 1'b0, f_en = 1'b0;
  logic t_en = 1'b0, all = 1'b0, all_mc = 1'b0, h_mode = 1'b0, rx_stop = 1'b0, wk_f = 1'b0;
  logic wk_m = 1'b0, wk_l = 1'b0, wk_e = 1'b0, da_v = 1'b0, irq, e_pl, e_dl, f_v, acc;
  logic [1:0] be;
  logic [3:0] pm_code = 4'h0;
  logic [5:0] h_ix;
  logic [7:0] addr, f_cnt = 8'h00;
  logic [15:0] wdata, rdata, v, int_en = 16'h0000, h2 = 16'h0000, h3 = 16'h0000;
  logic [15:0] b_cnt = 16'h0000, t_free = 16'h0000;
  logic [47:0] da = 48'h0;
  logic rx_set;
  int errors = 0, n_tests = 0, n_rx = 0, base;
  logic [7:0] offs [6] = '{8'h92, 8'h9c, 8'h9e, 8'ha0, 8'ha2, 8'h94};
  logic [3:0] codes [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [15:0] left [4] = '{16'h001c, 16'h000c, 16'h0004, 16'h0000};
  logic [47:0] das [3] = '{48'h01005e0000fb, 48'h333300000001, 48'h0180c2000001};

  // 100 MHz clock
  always #5 i_clock = ~i_clock;
  // Receive status pulses counted so a missed or doubled pulse shows
  always @(posedge i_clock) if (rx_set === 1'b1) n_rx <= n_rx + 1;

  heth_host_model u_host (.i_clock(i_clock), .o_cs(cs), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_be(be), .o_wdata(wdata), .i_rdata(rdata));
  heth_regs u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_cs(cs), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_be(be), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_int_enable(int_en), .i_pm_write(pm_wr), .i_pm_code(pm_code),
    .i_rx_byte_thr_en(b_en), .i_rx_frame_thr_en(f_en), .i_tx_monitor_en(t_en),
    .i_accept_all(all), .i_accept_all_mcast(all_mc), .i_hash_mode(h_mode),
    .i_hash_word_two(h2), .i_hash_word_three(h3), .i_rx_stopped(rx_stop),
    .i_wake_frame(wk_f), .i_magic_wake(wk_m), .i_linkup_wake(wk_l), .i_energy_wake(wk_e),
    .i_rx_byte_count(b_cnt), .i_rx_frame_count(f_cnt), .i_tx_free_dwords(t_free),
    .i_da_valid(da_v), .i_da(da), .o_rx_status_set(rx_set), .o_irq(irq),
    .o_energy_plain(e_pl), .o_energy_delayed(e_dl), .o_filter_valid(f_v),
    .o_mcast_accept(acc), .o_hash_index(h_ix));

  // Comparison of a seen value against the expected one
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reference CRC: octets first to last, each least significant bit first
  function automatic logic [5:0] hidx(input logic [47:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 47; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[(i / 8) * 8 + 7 - i % 8]) ?
      32'h04c11db7 : 32'h0);
    return c[31:26];
  endfunction

  // Whole table with one bit set, or with only that bit clear
  task automatic put_table(input logic [5:0] ix, input logic inv);
    logic [63:0] t;
    t = 64'h1 << ix;
    if (inv) t = ~t;
    u_host.wr16(HETH_OFF_HASH0, 2'b11, t[15:0]);
    u_host.wr16(HETH_OFF_HASH1, 2'b11, t[31:16]);
    h2 <= t[47:32];
    h3 <= t[63:48];
  endtask

  // One filter request; result checked the cycle after
  task automatic filt(input logic [47:0] d, input logic ea, input logic [5:0] ei);
    @(posedge i_clock);
    da_v <= 1'b1;
    da <= d;
    @(posedge i_clock);
    da_v <= 1'b0;
    da <= ~d;
    // Verdict launched at the taking edge, read at the following one
    @(posedge i_clock);
    chk(16'(f_v), 16'h1);
    chk(16'(acc), 16'(ea));
    chk(16'(h_ix), 16'(ei));
  endtask

  // Hang guard sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge i_clock);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    foreach (offs[i]) begin
      u_host.rd16(offs[i], v);
      chk(v, 16'h0000);
    end
    $display("reset values done");
    u_host.wr16(HETH_OFF_RX_THRESHOLD, 2'b11, 16'h1234);
    u_host.wr16(HETH_OFF_RX_THRESHOLD, 2'b01, 16'habcd);
    u_host.rd16(HETH_OFF_RX_THRESHOLD, v);
    chk(v, 16'h12cd);
    u_host.wr16(HETH_OFF_TX_REQUEST, 2'b10, 16'habcd);
    u_host.rd16(HETH_OFF_TX_REQUEST, v);
    chk(v, 16'hab00);
    $display("byte lanes done");
    int_en <= 16'h0100;
    @(posedge i_clock) rx_stop <= 1'b1;
    @(posedge i_clock) rx_stop <= 1'b0;
    u_host.wr16(HETH_OFF_STATUS, 2'b01, 16'hffff);
    u_host.rd16(HETH_OFF_STATUS, v);
    chk(v, 16'h0100);
    chk(16'(irq), 16'h1);
    u_host.wr16(HETH_OFF_STATUS, 2'b10, 16'h0100);
    repeat (2) @(posedge i_clock);
    #1 chk(16'(irq), 16'h0);
    u_host.rd16(HETH_OFF_STATUS, v);
    chk(v, 16'h0000);
    t_en <= 1'b1;
    int_en <= 16'h0040;
    t_free <= 16'h003f;
    u_host.req_space(16'h0040);
    u_host.rd16(HETH_OFF_STATUS, v);
    chk(v, 16'h0000);
    t_free <= 16'h0040;
    u_host.rd16(HETH_OFF_STATUS, v);
    chk(v, 16'h0040);
    chk(16'(irq), 16'h1);
    u_host.wr16(HETH_OFF_STATUS, 2'b01, 16'h0040);
    u_host.rd16(HETH_OFF_STATUS, v);
    chk(v, 16'h0000);
    $display("write-one-clear flags done");
    @(posedge i_clock) {wk_f, wk_m, wk_l, wk_e} <= 4'hf;
    @(posedge i_clock) {wk_f, wk_m, wk_l, wk_e} <= 4'h0;
    u_host.wr16(HETH_OFF_STATUS, 2'b11, 16'h003c);
    @(posedge i_clock) pm_write_code(4'h0);
    u_host.rd16(HETH_OFF_STATUS, v);
    chk(v, 16'h003c);
    @(posedge i_clock) int_en <= 16'h0004;
    #1 chk(16'({e_pl, e_dl}), 16'h2);
    @(posedge i_clock) int_en <= 16'h0005;
    #1 chk(16'({e_pl, e_dl}), 16'h1);
    foreach (codes[i]) begin
      pm_write_code(codes[i]);
      u_host.rd16(HETH_OFF_STATUS, v);
      chk(v, left[i]);
    end
    $display("wake flags done");
    u_host.set_rx_thr(8'h10, 8'h03, 1'b1);
    b_en <= 1'b1;
    base = n_rx;
    b_cnt <= 16'h0010;
    repeat (4) @(posedge i_clock);
    b_cnt <= 16'h0011;
    repeat (4) @(posedge i_clock);
    chk(16'(n_rx - base), 16'h1);
    b_en <= 1'b0;
    f_en <= 1'b1;
    f_cnt <= 8'h02;
    repeat (4) @(posedge i_clock);
    f_cnt <= 8'h03;
    repeat (4) @(posedge i_clock);
    chk(16'(n_rx - base), 16'h2);
    $display("thresholds done");
    h_mode <= 1'b1;
    foreach (das[i]) begin
      put_table(hidx(das[i]), 1'b0);
      filt(das[i], 1'b1, hidx(das[i]));
      put_table(hidx(das[i]), 1'b1);
      filt(das[i], 1'b0, hidx(das[i]));
    end
    all_mc <= 1'b1;
    filt(das[0], 1'b1, hidx(das[0]));
    all_mc <= 1'b0;
    all <= 1'b1;
    filt(das[0], 1'b1, hidx(das[0]));
    all <= 1'b0;
    put_table(hidx(das[0]), 1'b0);
    h_mode <= 1'b0;
    filt(das[0], 1'b0, hidx(das[0]));
    $display("hash filter done");
    close_out();
  end

  // Power-management write with its clear code
  task automatic pm_write_code(input logic [3:0] c);
    @(posedge i_clock);
    pm_wr <= 1'b1;
    pm_code <= c;
    @(posedge i_clock);
    pm_wr <= 1'b0;
    pm_code <= ~c;
  endtask
endmodule
`default_nettype wire

/* core/heth_pkg.sv */
package heth_pkg;
  // ==========================================================================
  // Register byte offsets on the host bus
  localparam logic [7:0] HETH_OFF_STATUS       = 8'h92;
  localparam logic [7:0] HETH_OFF_RX_THRESHOLD = 8'h9c;
  localparam logic [7:0] HETH_OFF_TX_REQUEST   = 8'h9e;
  localparam logic [7:0] HETH_OFF_HASH0        = 8'ha0;
  localparam logic [7:0] HETH_OFF_HASH1        = 8'ha2;

  // ==========================================================================
  // Status word bit positions held by this block, plus bit 0, the delay enable in the interrupt enable word
  localparam int HETH_BIT_RX_STOPPED  = 8;
  localparam int HETH_BIT_TX_SPACE    = 6;
  localparam int HETH_BIT_WAKE_FRAME  = 5;
  localparam int HETH_BIT_MAGIC_WAKE  = 4;
  localparam int HETH_BIT_LINKUP_WAKE = 3;
  localparam int HETH_BIT_ENERGY_WAKE = 2;
  localparam int HETH_BIT_DELAY_EN    = 0;

  // ==========================================================================
  // Threshold register fields
  localparam int HETH_BYTE_THR_MSB  = 15;
  localparam int HETH_BYTE_THR_LSB  = 8;
  localparam int HETH_FRAME_THR_MSB = 7;
  localparam int HETH_FRAME_THR_LSB = 0;

  // ==========================================================================
  // Power-management clear codes written to control bits 5:2
  localparam logic [3:0] HETH_PM_CLR_WAKE_FRAME  = 4'h8;
  localparam logic [3:0] HETH_PM_CLR_MAGIC_WAKE  = 4'h4;
  localparam logic [3:0] HETH_PM_CLR_LINKUP_WAKE = 4'h2;
  localparam logic [3:0] HETH_PM_CLR_ENERGY_WAKE = 4'h1;

  // ==========================================================================
  // Reset values and hash constants
  localparam logic [15:0] HETH_RST_WORD   = 16'h0000;
  localparam logic [31:0] HETH_CRC_INIT   = 32'hffffffff;
  localparam logic [31:0] HETH_CRC_POLY   = 32'h04c11db7;
  localparam int          HETH_GROUP_BIT  = 40;
endpackage

/* core/heth_regs.sv */
`timescale 1ns/10ps
`default_nettype none

module heth_regs
  import heth_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Host register port
  input  wire logic        i_reg_cs,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [1:0]  i_reg_be,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  // Neighbouring control registers
  input  wire logic [15:0] i_int_enable,
  input  wire logic        i_pm_write,
  input  wire logic [3:0]  i_pm_code,
  input  wire logic        i_rx_byte_thr_en,
  input  wire logic        i_rx_frame_thr_en,
  input  wire logic        i_tx_monitor_en,
  input  wire logic        i_accept_all,
  input  wire logic        i_accept_all_mcast,
  input  wire logic        i_hash_mode,
  input  wire logic [15:0] i_hash_word_two,
  input  wire logic [15:0] i_hash_word_three,
  // Events from the queues and wake logic
  input  wire logic        i_rx_stopped,
  input  wire logic        i_wake_frame,
  input  wire logic        i_magic_wake,
  input  wire logic        i_linkup_wake,
  input  wire logic        i_energy_wake,
  input  wire logic [15:0] i_rx_byte_count,
  input  wire logic [7:0]  i_rx_frame_count,
  input  wire logic [15:0] i_tx_free_dwords,
  // Address filter request
  input  wire logic        i_da_valid,
  input  wire logic [47:0] i_da,
  // Results
  output logic             o_rx_status_set,
  output logic             o_irq,
  output logic             o_energy_plain,
  output logic             o_energy_delayed,
  output logic             o_filter_valid,
  output logic             o_mcast_accept,
  output logic      [5:0]  o_hash_index
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        rx_stopped_flag;
    logic        tx_space_flag;
    logic        wake_frame_flag;
    logic        magic_wake_flag;
    logic        linkup_wake_flag;
    logic        energy_wake_flag;
    logic [15:0] rx_frame_threshold_ctrl;
    logic [15:0] tx_next_space_request;
    logic [15:0] multicast_hash_word0;
    logic [15:0] multicast_hash_word1;
    logic [15:0] rdata;
    logic        rx_cond;
    logic        tx_cond;
    logic        rx_pulse;
    logic        irq;
    logic        filter_valid;
    logic        mcast_accept;
    logic [5:0]  hash_index;
  } heth_state_s;

  heth_state_s state;
  heth_state_s next_state;

  // ==========================================================================
  // Helpers

  // Serial CRC over the destination, first octet in bits 47:40, each octet LSB first
  function automatic logic [31:0] heth_crc(input logic [47:0] da);
    logic [31:0] crc;
    logic        fb;
    crc = HETH_CRC_INIT;
    for (int b = 0; b < 6; b++) begin
      for (int k = 0; k < 8; k++) begin
        fb  = crc[31] ^ da[47 - 8 * b - 7 + k];
        crc = {crc[30:0], 1'b0} ^ (fb ? HETH_CRC_POLY : 32'h00000000);
      end
    end
    return crc;
  endfunction

  logic        wr_hit;
  logic [15:0] wmask;
  logic [15:0] status_view;
  logic [31:0] crc_value;
  logic [5:0]  index_now;
  logic [15:0] table_word;
  logic        rx_cond_now;
  logic        tx_cond_now;
  logic        w1c_rx;
  logic        w1c_tx;

  // Byte lanes turn into a bit mask so partial writes leave the other lane alone
  assign wr_hit = i_reg_cs & i_reg_wr;
  assign wmask  = {{8{i_reg_be[1]}}, {8{i_reg_be[0]}}};

  // Only the flags owned here appear; every other position reads zero
  always_comb begin
    status_view                       = 16'h0000;
    status_view[HETH_BIT_RX_STOPPED]  = state.rx_stopped_flag;
    status_view[HETH_BIT_TX_SPACE]    = state.tx_space_flag;
    status_view[HETH_BIT_WAKE_FRAME]  = state.wake_frame_flag;
    status_view[HETH_BIT_MAGIC_WAKE]  = state.magic_wake_flag;
    status_view[HETH_BIT_LINKUP_WAKE] = state.linkup_wake_flag;
    status_view[HETH_BIT_ENERGY_WAKE] = state.energy_wake_flag;
  end

  // Write-one-clear strobes for the two host-clearable flags
  assign w1c_rx = wr_hit && (i_reg_addr == HETH_OFF_STATUS)
                  && i_reg_be[1] && i_reg_wdata[HETH_BIT_RX_STOPPED];
  assign w1c_tx = wr_hit && (i_reg_addr == HETH_OFF_STATUS)
                  && i_reg_be[0] && i_reg_wdata[HETH_BIT_TX_SPACE];

  // Threshold conditions; a zero frame threshold is the host's to avoid
  assign rx_cond_now =
    (i_rx_byte_thr_en &&
     (i_rx_byte_count > {8'h00, state.rx_frame_threshold_ctrl[HETH_BYTE_THR_MSB:HETH_BYTE_THR_LSB]}))
    || (i_rx_frame_thr_en &&
     (i_rx_frame_count >=
      state.rx_frame_threshold_ctrl[HETH_FRAME_THR_MSB:HETH_FRAME_THR_LSB]));
  assign tx_cond_now = i_tx_monitor_en
                       && (i_tx_free_dwords >= state.tx_next_space_request);

  // Hash lookup: top two index bits choose the word, the rest the bit
  assign crc_value = heth_crc(i_da);
  assign index_now = crc_value[31:26];
  always_comb begin
    case (index_now[5:4])
      2'h0:    table_word = state.multicast_hash_word0;
      2'h1:    table_word = state.multicast_hash_word1;
      2'h2:    table_word = i_hash_word_two;
      default: table_word = i_hash_word_three;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_state = state;

    // Flag set wins over a clear arriving in the same cycle
    if (w1c_rx) begin
      next_state.rx_stopped_flag = 1'b0;
    end
    if (i_rx_stopped) begin
      next_state.rx_stopped_flag = 1'b1;
    end
    if (w1c_tx) begin
      next_state.tx_space_flag = 1'b0;
    end
    if (tx_cond_now && !state.tx_cond) begin
      next_state.tx_space_flag = 1'b1;
    end

    // Wake flags ignore status writes; only exact power-management codes clear
    if (i_pm_write && (i_pm_code == HETH_PM_CLR_WAKE_FRAME)) begin
      next_state.wake_frame_flag = 1'b0;
    end
    if (i_pm_write && (i_pm_code == HETH_PM_CLR_MAGIC_WAKE)) begin
      next_state.magic_wake_flag = 1'b0;
    end
    if (i_pm_write && (i_pm_code == HETH_PM_CLR_LINKUP_WAKE)) begin
      next_state.linkup_wake_flag = 1'b0;
    end
    if (i_pm_write && (i_pm_code == HETH_PM_CLR_ENERGY_WAKE)) begin
      next_state.energy_wake_flag = 1'b0;
    end
    if (i_wake_frame) begin
      next_state.wake_frame_flag = 1'b1;
    end
    if (i_magic_wake) begin
      next_state.magic_wake_flag = 1'b1;
    end
    if (i_linkup_wake) begin
      next_state.linkup_wake_flag = 1'b1;
    end
    if (i_energy_wake) begin
      next_state.energy_wake_flag = 1'b1;
    end

    // Register writes, lane by lane
    if (wr_hit) begin
      if (i_reg_addr == HETH_OFF_RX_THRESHOLD) begin
        next_state.rx_frame_threshold_ctrl =
          (state.rx_frame_threshold_ctrl & ~wmask) | (i_reg_wdata & wmask);
      end else if (i_reg_addr == HETH_OFF_TX_REQUEST) begin
        next_state.tx_next_space_request =
          (state.tx_next_space_request & ~wmask) | (i_reg_wdata & wmask);
      end else if (i_reg_addr == HETH_OFF_HASH0) begin
        next_state.multicast_hash_word0 =
          (state.multicast_hash_word0 & ~wmask) | (i_reg_wdata & wmask);
      end else if (i_reg_addr == HETH_OFF_HASH1) begin
        next_state.multicast_hash_word1 =
          (state.multicast_hash_word1 & ~wmask) | (i_reg_wdata & wmask);
      end
    end

    // Read data is registered; unmapped offsets return zero
    if (i_reg_cs && i_reg_rd) begin
      if (i_reg_addr == HETH_OFF_STATUS) begin
        next_state.rdata = status_view;
      end else if (i_reg_addr == HETH_OFF_RX_THRESHOLD) begin
        next_state.rdata = state.rx_frame_threshold_ctrl;
      end else if (i_reg_addr == HETH_OFF_TX_REQUEST) begin
        next_state.rdata = state.tx_next_space_request;
      end else if (i_reg_addr == HETH_OFF_HASH0) begin
        next_state.rdata = state.multicast_hash_word0;
      end else if (i_reg_addr == HETH_OFF_HASH1) begin
        next_state.rdata = state.multicast_hash_word1;
      end else begin
        next_state.rdata = 16'h0000;
      end
    end

    // Receive flag is edge-raised so a standing backlog does not re-fire every cycle
    next_state.rx_cond  = rx_cond_now;
    next_state.tx_cond  = tx_cond_now;
    next_state.rx_pulse = rx_cond_now && !state.rx_cond;

    // Interrupt from the flags held here, gated by their enables
    next_state.irq = |(status_view & i_int_enable);

    // Filter verdict one cycle after the destination is offered
    next_state.filter_valid = i_da_valid;
    if (i_da_valid) begin
      next_state.hash_index   = index_now;
      next_state.mcast_accept = i_da[HETH_GROUP_BIT]
        && (i_accept_all || i_accept_all_mcast
            || (i_hash_mode && table_word[index_now[3:0]]));
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state                         <= '0;
      state.rx_frame_threshold_ctrl <= HETH_RST_WORD;
      state.tx_next_space_request   <= HETH_RST_WORD;
      state.multicast_hash_word0    <= HETH_RST_WORD;
      state.multicast_hash_word1    <= HETH_RST_WORD;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_reg_rdata      = state.rdata;
  assign o_rx_status_set  = state.rx_pulse;
  assign o_irq            = state.irq;
  assign o_filter_valid   = state.filter_valid;
  assign o_mcast_accept   = state.mcast_accept;
  assign o_hash_index     = state.hash_index;
  // Energy wake kind follows the two enables at the moment it is read
  assign o_energy_plain   = state.energy_wake_flag && i_int_enable[HETH_BIT_ENERGY_WAKE]
                            && !i_int_enable[HETH_BIT_DELAY_EN];
  assign o_energy_delayed = state.energy_wake_flag && i_int_enable[HETH_BIT_ENERGY_WAKE]
                            && i_int_enable[HETH_BIT_DELAY_EN];

  // ==========================================================================
  // Assertions
  property p_rx_stop_set;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_rx_stopped |=> state.rx_stopped_flag;
  endproperty
  a_rx_stop_set: assert property (p_rx_stop_set) else $error("stop flag not set");

  property p_rx_stop_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      state.rx_stopped_flag && !w1c_rx |=> state.rx_stopped_flag;
  endproperty
  a_rx_stop_hold: assert property (p_rx_stop_hold) else $error("stop flag lost");

  property p_tx_space;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_tx_monitor_en && (i_tx_free_dwords >= state.tx_next_space_request) && !state.tx_cond
      |=> state.tx_space_flag;
  endproperty
  a_tx_space: assert property (p_tx_space) else $error("tx space flag missed");

  property p_wake_frame_clr;
    @(posedge i_clock) disable iff (!i_rst_n)
      state.wake_frame_flag && !(i_pm_write && i_pm_code == 4'h8) |=> state.wake_frame_flag;
  endproperty
  a_wake_frame_clr: assert property (p_wake_frame_clr) else $error("wake flag cleared");

  property p_energy_clr;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_pm_write && i_pm_code == 4'h1 && !i_energy_wake |=> !state.energy_wake_flag;
  endproperty
  a_energy_clr: assert property (p_energy_clr) else $error("energy flag kept");

  property p_rx_frame_thr;
    @(posedge i_clock) disable iff (!i_rst_n)
      !state.rx_cond && i_rx_frame_thr_en && i_rx_frame_count >= state.rx_frame_threshold_ctrl[7:0]
      |=> o_rx_status_set;
  endproperty
  a_rx_frame_thr: assert property (p_rx_frame_thr) else $error("rx threshold missed");

  property p_irq;
    @(posedge i_clock) disable iff (!i_rst_n)
      |(status_view & i_int_enable) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_reserved;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_reg_cs && i_reg_rd && i_reg_addr == HETH_OFF_STATUS |=> (o_reg_rdata & 16'hfe83) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit read one");

  property p_accept_all;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_da_valid && i_da[40] && i_accept_all_mcast |=> o_filter_valid && o_mcast_accept;
  endproperty
  a_accept_all: assert property (p_accept_all) else $error("multicast dropped");

  property p_hash_off;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_da_valid && !i_hash_mode && !i_accept_all && !i_accept_all_mcast |=> !o_mcast_accept;
  endproperty
  a_hash_off: assert property (p_hash_off) else $error("hash used outside mode");

endmodule

`default_nettype wire
